// [design/oad_bit_map.sv]
// Bit address to byte address mapper with validity check
`timescale 1ns/10ps

module oad_bit_map
  import oad_pkg::*;
(
  // Bit address from the instruction
  input  wire logic [7:0] bit_addr,
  // Mapped location
  output logic      [7:0] byte_addr,
  output logic      [2:0] bit_idx,
  output logic            is_sfr,
  output logic            accepted
);

  // ==========================================================================
  // Mapping
  // ==========================================================================
  // Low half packs 16 RAM bytes, high half lands on aligned SPECIAL_FUNCTION_SPACE bases
  assign is_sfr    = bit_addr[7];
  assign bit_idx   = bit_addr[2:0];
  assign byte_addr = is_sfr ? {bit_addr[7:3], OAD_BIT_SFR_LOW}
                            : {OAD_BIT_RAM_HIGH, bit_addr[6:3]};

  // ==========================================================================
  // Validity
  // ==========================================================================
  // Bit area check
  // Kept explicit so a remapped encoding cannot slip outside the areas
  assign accepted = is_sfr ? ((byte_addr[3:0] == OAD_BIT_SFR_NIB_A) ||
                              (byte_addr[3:0] == OAD_BIT_SFR_NIB_B))
                           : ((byte_addr >= OAD_BIT_RAM_FIRST) &&
                              (byte_addr <= OAD_BIT_RAM_LAST));

endmodule

// [design/oad_operand_decode.sv]
// Operand address decoder with internal data RAM and auxiliary register
`timescale 1ns/10ps

module oad_operand_decode
  import oad_pkg::*;
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Request from the execute logic
  input  wire logic             req_valid,
  input  wire oad_pkg::oad_mode_t req_mode,
  input  wire logic [7:0]       req_opcode,
  input  wire logic [7:0]       req_operand,
  input  wire logic             req_write,
  input  wire logic [7:0]       req_wdata,
  input  wire logic             req_wbit,
  input  wire logic [1:0]       bank_sel,
  // Answer, one cycle after the request
  output logic                  rsp_valid,
  output logic      [7:0]       rsp_rdata,
  output logic                  rsp_rbit,
  output logic      [7:0]       rsp_addr,
  output logic                  rsp_to_ram,
  output logic                  rsp_to_sfr,
  output logic                  rsp_unmapped,
  output logic                  rsp_refused,
  // Register contents
  output logic      [7:0]       aux_value
);

  import oad_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed
  {
    logic [OAD_RAM_DEPTH-1:0][7:0] ram;
    logic [7:0]                    aux;
    logic                          rsp_valid;
    logic [7:0]                    rdata;
    logic                          rbit;
    logic [7:0]                    addr;
    logic                          to_ram;
    logic                          to_sfr;
    logic                          unmapped;
    logic                          refused;
  } oad_state_t;

  oad_state_t  st_r;
  oad_state_t  st_nxt;

  // ==========================================================================
  // Address sources
  // ==========================================================================
  logic [7:0]  wreg_addr;
  logic [7:0]  ptr_addr;
  logic [7:0]  ptr_value;
  logic [7:0]  bm_byte;
  logic [2:0]  bm_idx;
  logic        bm_sfr;
  logic        bm_ok;

  // Register selection
  // Bank select places the eight registers; no operand byte is used
  assign wreg_addr = {OAD_WREG_PAD, bank_sel,
                      req_opcode[OAD_WREG_SEL_LSB +: OAD_WREG_SEL_W]};

  // Pointer is the first or second working register of the bank
  assign ptr_addr  = {OAD_WREG_PAD, bank_sel, OAD_PTR_PAD, req_opcode[0]};
  assign ptr_value = st_r.ram[ptr_addr];

  oad_bit_map u_bit_map
  (
    .bit_addr  (req_operand),
    .byte_addr (bm_byte),
    .bit_idx   (bm_idx),
    .is_sfr    (bm_sfr),
    .accepted  (bm_ok)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    logic [7:0] eff;
    logic       to_sfr;
    logic       refused;
    logic [2:0] idx;
    logic       is_aux;
    logic [7:0] rd_byte;
    logic [7:0] wr_byte;
    eff     = OAD_RAM_LOW_FIRST;
    to_sfr  = 1'b0;
    refused = 1'b0;
    idx     = 3'h0;
    is_aux  = 1'b0;
    rd_byte = OAD_UNMAPPED_READ;
    wr_byte = OAD_UNMAPPED_READ;
    st_nxt  = st_r;
    st_nxt.rsp_valid = 1'b0;

    case (req_mode)
      OAD_MODE_REG:
      begin
        eff = wreg_addr;
      end
      OAD_MODE_DIRECT:
      begin
        eff = req_operand;
        to_sfr = (req_operand >= OAD_SFR_FIRST);
      end
      OAD_MODE_INDIRECT:
      begin
        // Pointer hits RAM
        // Same numbers as SFRs, but indirect never leaves the RAM array
        eff    = ptr_value;
        to_sfr = 1'b0;
      end
      OAD_MODE_BIT:
      begin
        eff     = bm_byte;
        to_sfr  = bm_sfr;
        idx     = bm_idx;
        refused = !bm_ok;
      end
      default:
      begin
        eff = OAD_RAM_LOW_FIRST;
      end
    endcase

    is_aux = to_sfr && (eff == OAD_AUX_ADDR);

    if (!to_sfr)
      rd_byte = st_r.ram[eff];
    else if (is_aux)
      rd_byte = st_r.aux;
    else
      rd_byte = OAD_UNMAPPED_READ;

    // Bit writes are read-modify-write on the whole byte
    if (req_mode == OAD_MODE_BIT)
    begin
      wr_byte      = rd_byte;
      wr_byte[idx] = req_wbit;
    end
    else
    begin
      wr_byte = req_wdata;
    end

    if (req_valid)
    begin
      st_nxt.rsp_valid = 1'b1;
      st_nxt.rdata     = refused ? OAD_UNMAPPED_READ : rd_byte;
      st_nxt.rbit      = refused ? 1'b0 : rd_byte[idx];
      st_nxt.addr      = eff;
      st_nxt.to_ram    = !to_sfr && !refused;
      st_nxt.to_sfr    = to_sfr && !refused;
      st_nxt.unmapped  = to_sfr && !is_aux && !refused;
      st_nxt.refused   = refused;
      if (req_write && !refused)
      begin
        if (!to_sfr)
          st_nxt.ram[eff] = wr_byte;
        else if (is_aux)
          st_nxt.aux = wr_byte;
        else
          st_nxt.aux = st_r.aux;
      end
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Clearing the RAM at reset costs area but gives defined reads
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r     <= '0;
      st_r.aux <= OAD_AUX_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign rsp_valid    = st_r.rsp_valid;
  assign rsp_rdata    = st_r.rdata;
  assign rsp_rbit     = st_r.rbit;
  assign rsp_addr     = st_r.addr;
  assign rsp_to_ram   = st_r.to_ram;
  assign rsp_to_sfr   = st_r.to_sfr;
  assign rsp_unmapped = st_r.unmapped;
  assign rsp_refused  = st_r.refused;
  assign aux_value    = st_r.aux;

endmodule

// [design/oad_pkg.sv]
// Package of constants and types for the operand address decoder
package oad_pkg;

  // ==========================================================================
  // Address space layout
  // ==========================================================================
  localparam logic [7:0] OAD_RAM_LOW_FIRST  = 8'h00;
  localparam logic [7:0] OAD_RAM_LOW_LAST   = 8'h7F;
  localparam logic [7:0] OAD_SFR_FIRST      = 8'h80;
  localparam logic [7:0] OAD_SFR_LAST       = 8'hFF;
  localparam int         OAD_RAM_DEPTH      = 256;

  // ==========================================================================
  // Working register and pointer selection
  // ==========================================================================
  localparam int         OAD_WREG_SEL_LSB   = 0;
  localparam int         OAD_WREG_SEL_W     = 3;
  localparam int         OAD_BANK_W         = 2;
  localparam logic [2:0] OAD_WREG_PAD       = 3'h0;
  localparam logic [1:0] OAD_PTR_PAD        = 2'h0;

  // ==========================================================================
  // Arithmetic auxiliary register
  // ==========================================================================
  localparam logic [7:0] OAD_AUX_ADDR       = 8'hF0;
  localparam logic [7:0] OAD_AUX_RESET      = 8'h00;
  localparam logic [7:0] OAD_UNMAPPED_READ  = 8'h00;

  // ==========================================================================
  // Bit addressable areas
  // ==========================================================================
  localparam logic [7:0] OAD_BIT_RAM_FIRST  = 8'h20;
  localparam logic [7:0] OAD_BIT_RAM_LAST   = 8'h2F;
  localparam logic [3:0] OAD_BIT_RAM_HIGH   = 4'h2;
  localparam logic [3:0] OAD_BIT_SFR_NIB_A  = 4'h0;
  localparam logic [3:0] OAD_BIT_SFR_NIB_B  = 4'h8;
  localparam logic [2:0] OAD_BIT_SFR_LOW    = 3'h0;

  // ==========================================================================
  // Addressing modes
  // ==========================================================================
  typedef enum logic [1:0]
  {
    OAD_MODE_REG,
    OAD_MODE_DIRECT,
    OAD_MODE_INDIRECT,
    OAD_MODE_BIT
  } oad_mode_t;

endpackage

// [verification/oad_exec_model.sv]
// Execute-side request driver for the decoder
`timescale 1ns/10ps
module oad_exec_model
  import oad_pkg::*;
(
  // Clock
  input  wire logic         sys_clk,
  // Request
  output oad_pkg::oad_mode_t req_mode,
  output logic              req_valid,
  output logic [7:0]        req_opcode,
  output logic [7:0]        req_operand,
  output logic              req_write,
  output logic [7:0]        req_wdata,
  output logic              req_wbit,
  output logic [1:0]        bank_sel
);
  initial
  begin
    req_mode = OAD_MODE_REG;
    {req_valid, req_opcode, req_operand, req_write, req_wdata, req_wbit, bank_sel} = '0;
  end
  // Fields held until the taking edge
  task automatic issue(input oad_mode_t m, input logic [7:0] opc, opr,
    input logic wr, input logic [7:0] wd, input logic wb, input logic [1:0] bk);
  begin
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_mode <= m;
    {req_opcode, req_operand, req_write} <= {opc, opr, wr};
    {req_wdata, req_wbit, bank_sel} <= {wd, wb, bk};
    @(posedge sys_clk);
    req_valid <= 1'b0;
  end
  endtask
endmodule

// [verification/oad_operand_decode_asserts.sv]
// Checker for the operand decoder ports
`timescale 1ns/10ps
module oad_operand_decode_asserts
  import oad_pkg::*;
(
  // Clock, reset and request
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire logic               req_valid,
  input wire oad_pkg::oad_mode_t req_mode,
  input wire logic [7:0]         req_opcode,
  input wire logic [7:0]         req_operand,
  input wire logic               req_write,
  input wire logic [7:0]         req_wdata,
  input wire logic [1:0]         bank_sel,
  // Answer
  input wire logic               rsp_valid,
  input wire logic [7:0]         rsp_rdata,
  input wire logic [7:0]         rsp_addr,
  input wire logic               rsp_to_ram,
  input wire logic               rsp_to_sfr,
  input wire logic               rsp_unmapped,
  input wire logic               rsp_refused,
  input wire logic [7:0]         aux_value
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic dir;
  assign dir = req_valid && req_mode == OAD_MODE_DIRECT;
  AST_ANSWER: assert property (req_valid |=> rsp_valid)
    else $error("answer missing");
  AST_REG_ADDR: assert property (req_valid && req_mode == OAD_MODE_REG |=>
    rsp_to_ram && rsp_addr == {3'h0, $past(bank_sel), $past(req_opcode[2:0])})
    else $error("register address wrong");
  AST_DIR_RAM: assert property (dir && !req_operand[7] |=>
    rsp_to_ram && !rsp_to_sfr && rsp_addr == $past(req_operand))
    else $error("low direct not routed to ram");
  AST_DIR_SFR: assert property (dir && req_operand[7] |=> rsp_to_sfr && !rsp_to_ram)
    else $error("high direct not routed to sfr");
  AST_AUX_WR: assert property (dir && req_write && req_operand == OAD_AUX_ADDR |=>
    aux_value == $past(req_wdata))
    else $error("aux write lost");
  AST_AUX_RD: assert property (dir && req_operand == OAD_AUX_ADDR |=>
    rsp_rdata == $past(aux_value))
    else $error("aux read wrong");
  AST_IND_RAM: assert property (req_valid && req_mode == OAD_MODE_INDIRECT |=>
    rsp_to_ram && !rsp_to_sfr)
    else $error("indirect reached sfr");
  AST_BIT_OK: assert property (req_valid && req_mode == OAD_MODE_BIT |=> !rsp_refused
    && (rsp_to_ram ? rsp_addr[7:4] == 4'h2 : rsp_addr[2:0] == 3'h0))
    else $error("bit access refused or misplaced");
  AST_UNMAP: assert property (dir && req_operand[7] && req_operand != OAD_AUX_ADDR |=>
    rsp_unmapped && rsp_rdata == OAD_UNMAPPED_READ && $stable(aux_value))
    else $error("unmapped access not inert");
endmodule

bind oad_operand_decode oad_operand_decode_asserts u_chk (.sys_clk, .rst_n, .req_valid,
  .req_mode, .req_opcode, .req_operand, .req_write, .req_wdata, .bank_sel, .rsp_valid,
  .rsp_rdata, .rsp_addr, .rsp_to_ram, .rsp_to_sfr, .rsp_unmapped, .rsp_refused, .aux_value);

// [verification/oad_operand_decode_tb.sv]
// Self-checking bench for the operand decoder
`timescale 1ns/10ps
module oad_operand_decode_tb;
  import oad_pkg::*;
  logic       sys_clk, rst_n, req_valid, req_write, req_wbit, rsp_valid, rsp_rbit;
  logic       rsp_to_ram, rsp_to_sfr, rsp_unmapped, rsp_refused;
  oad_mode_t  req_mode;
  logic [7:0] req_opcode, req_operand, req_wdata, rsp_rdata, rsp_addr, aux_value;
  logic [1:0] bank_sel;
  int         n_fail, checks;
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;
  oad_operand_decode i_dut (.sys_clk, .rst_n, .req_valid, .req_mode, .req_opcode,
    .req_operand, .req_write, .req_wdata, .req_wbit, .bank_sel, .rsp_valid, .rsp_rdata,
    .rsp_rbit, .rsp_addr, .rsp_to_ram, .rsp_to_sfr, .rsp_unmapped, .rsp_refused, .aux_value);
  oad_exec_model i_exec (.sys_clk, .req_mode, .req_valid, .req_opcode, .req_operand,
    .req_write, .req_wdata, .req_wbit, .bank_sel);
  task automatic chk(input logic [7:0] seen, exp);
  begin
    checks++;
    if (seen !== exp)
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    if (seen !== exp)
      n_fail++;
  end
  endtask
  task automatic conclude;
  begin
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // Answer is read just after the taking edge
  task automatic op(input oad_mode_t m, input logic [7:0] opc, opr,
    input logic wr, input logic [7:0] wd, input logic wb, input logic [1:0] bk);
  begin
    i_exec.issue(m, opc, opr, wr, wd, wb, bk);
    #1;
    // Every access lands in exactly one place or is refused
    chk({7'h00, rsp_to_ram ^ rsp_to_sfr ^ rsp_refused}, 8'h01);
    chk({7'h00, rsp_valid}, 8'h01);
  end
  endtask
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    conclude;
  end
  initial
  begin
    n_fail = 0;
    checks = 0;
    rst_n = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk(aux_value, 8'h00);
    op(OAD_MODE_DIRECT, 8'h00, 8'hF0, 1'b1, 8'h5A, 1'b0, 2'h0);
    chk({rsp_to_sfr, rsp_to_ram, aux_value[5:0]}, 8'h9A);
    op(OAD_MODE_DIRECT, 8'h00, 8'h7F, 1'b1, 8'h3C, 1'b0, 2'h0);
    op(OAD_MODE_DIRECT, 8'h00, 8'h7F, 1'b0, 8'h00, 1'b0, 2'h0);
    chk(rsp_rdata, 8'h3C);
    chk({rsp_to_sfr, rsp_to_ram, 6'h00}, 8'h40);
    op(OAD_MODE_DIRECT, 8'h00, 8'h0F, 1'b1, 8'h77, 1'b0, 2'h0);
    op(OAD_MODE_REG, 8'hAF, 8'h00, 1'b0, 8'h00, 1'b0, 2'h1);
    chk(rsp_addr, 8'h0F);
    chk(rsp_rdata, 8'h77);
    op(OAD_MODE_DIRECT, 8'h00, 8'h01, 1'b1, 8'h90, 1'b0, 2'h0);
    op(OAD_MODE_INDIRECT, 8'h01, 8'h00, 1'b1, 8'hA5, 1'b0, 2'h0);
    op(OAD_MODE_INDIRECT, 8'h01, 8'h00, 1'b0, 8'h00, 1'b0, 2'h0);
    chk(rsp_rdata, 8'hA5);
    chk({rsp_to_sfr, rsp_to_ram, rsp_addr[5:0]}, 8'h50);
    op(OAD_MODE_DIRECT, 8'h00, 8'h90, 1'b0, 8'h00, 1'b0, 2'h0);
    chk({rsp_unmapped, rsp_rdata[6:0]}, 8'h80);
    op(OAD_MODE_DIRECT, 8'h00, 8'hF1, 1'b1, 8'hFF, 1'b0, 2'h0);
    chk(aux_value, 8'h5A);
    op(OAD_MODE_BIT, 8'h00, 8'hF2, 1'b1, 8'h00, 1'b1, 2'h0);
    chk(aux_value, 8'h5E);
    chk({rsp_refused, rsp_rbit, rsp_addr[5:0]}, 8'h30);
    op(OAD_MODE_BIT, 8'h00, 8'h7D, 1'b1, 8'h00, 1'b1, 2'h0);
    chk({rsp_refused, rsp_addr[6:0]}, 8'h2F);
    op(OAD_MODE_DIRECT, 8'h00, 8'h2F, 1'b0, 8'h00, 1'b0, 2'h0);
    chk(rsp_rdata, 8'h20);
    // Bit read of a set bit, so a stuck bit output is caught
    op(OAD_MODE_BIT, 8'h00, 8'hF3, 1'b0, 8'h00, 1'b0, 2'h0);
    chk({7'h00, rsp_rbit}, 8'h01);
    // Mid-run reset must bring the auxiliary register back to zero
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk(aux_value, 8'h00);
    op(OAD_MODE_DIRECT, 8'h00, 8'hF0, 1'b0, 8'h00, 1'b0, 2'h0);
    chk(rsp_rdata, 8'h00);
    conclude;
  end
endmodule
